// ### rtl/mrq_pkg.sv
// constants, fields and states of the monitor receive interrupt queue writer
// Operation
// - read slot status first; if free write bytes, then status with new flag set
// - slot still flagged when posting sets the queue overflow interrupt bit
// - multiplex select is 0 for the first multiplex, 1 for the second
// - last and single set means final byte sits in following data word
// - last set, single clear means final byte went in previous channel entry
// - last flag clear when neither neighbouring word holds the final byte
// - first flag set only when the following data word holds the first byte
// - abort flag set when the received monitor message was aborted
// - single flag is 1 for one byte in data word, 0 for two
// - lower byte is doubly confirmed under GCI, single reception under V star
// - upper byte is next confirmed byte under GCI, all ones under V star
// - with time stamping the captured free running 16-bit counter is written
// - plain entry is status word then data word, fields at fixed positions
// - stamped entry is status, data, time stamp, then an all-zero word
// - under V star single, abort, first, last flags are 1, 0, 1, 1
package mrq_pkg;
  localparam int          MRQ_AXI_AW       = 8;
  localparam int          MRQ_MEM_AW       = 24;
  // register byte offsets
  localparam logic [7:0]  MRQ_OFF_CFG      = 8'h00;
  localparam logic [7:0]  MRQ_OFF_BASE     = 8'h04;
  localparam logic [7:0]  MRQ_OFF_SIZE     = 8'h08;
  localparam logic [7:0]  MRQ_OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0]  MRQ_OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0]  MRQ_OFF_STATUS   = 8'h14;
  // values after reset
  localparam logic        MRQ_STAMP_RST    = 1'b0;
  localparam logic [23:0] MRQ_BASE_RST     = 24'h000000;
  localparam logic [15:0] MRQ_SIZE_RST     = 16'h0010;
  // status word field positions
  localparam int          MRQ_NEW_BIT      = 15;
  localparam int          MRQ_MUX_BIT      = 11;
  localparam int          MRQ_CHAN_LSB     = 8;
  localparam int          MRQ_ODD_BIT      = 3;
  localparam int          MRQ_ABORT_BIT    = 2;
  localparam int          MRQ_FIRST_BIT    = 1;
  localparam int          MRQ_LAST_BIT     = 0;
  // word offsets inside one entry
  localparam logic [1:0]  MRQ_WO_STAT      = 2'h0;
  localparam logic [1:0]  MRQ_WO_DATA      = 2'h1;
  localparam logic [1:0]  MRQ_WO_TS        = 2'h2;
  localparam logic [1:0]  MRQ_WO_ZERO      = 2'h3;
  // fixed contents under the V star protocol
  localparam logic [7:0]  MRQ_VSTAR_UPPER  = 8'hff;
  localparam logic [3:0]  MRQ_VSTAR_FLAGS  = 4'hb;
  // axi responses
  localparam logic [1:0]  MRQ_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  MRQ_RESP_SLVERR  = 2'h2;
  typedef enum logic [5:0] {
    MRQ_S_IDLE = 6'h01,
    MRQ_S_RDNS = 6'h02,
    MRQ_S_DATA = 6'h04,
    MRQ_S_TS   = 6'h08,
    MRQ_S_ZERO = 6'h10,
    MRQ_S_STAT = 6'h20
  } mrq_state_t;
endpackage

// ### rtl/mrq_writer.sv
// monitor receive event poster into the shared-memory interrupt queue
`timescale 1ns/1ns
`default_nettype none
module mrq_writer (
  // clock, reset, enable
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  // axi4-lite register slave
  input  wire logic [mrq_pkg::MRQ_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [mrq_pkg::MRQ_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // received monitor events
  input  wire logic                           ev_valid,
  output logic                                ev_ready,
  input  wire logic                           ev_vstar,
  input  wire logic                           ev_multiplex_select,
  input  wire logic [2:0]                     ev_channel_number,
  input  wire logic                           ev_odd,
  input  wire logic                           ev_abort,
  input  wire logic                           ev_first,
  input  wire logic                           ev_last,
  input  wire logic [7:0]                     ev_lower_monitor_byte,
  input  wire logic [7:0]                     ev_upper_monitor_byte,
  // shared memory word port
  output logic                                mem_req,
  output logic                                mem_we,
  output logic [mrq_pkg::MRQ_MEM_AW-1:0]      mem_addr,
  output logic [15:0]                         mem_wdata,
  input  wire logic                           mem_ack,
  input  wire logic [15:0]                    mem_rdata,
  // interrupt
  output logic                                irq
);
  import mrq_pkg::*;

  mrq_state_t  state;
  mrq_state_t  next_state;
  logic        time_stamp_enable;
  logic [23:0] queue_base;
  logic [15:0] queue_size;
  logic        monitor_queue_overflow;
  logic        overflow_mask;
  logic [15:0] wr_ptr;
  logic [15:0] time_stamp_value;
  logic [15:0] free_counter;
  logic        stamp_q;
  logic        vstar_q;
  logic        mux_q;
  logic [2:0]  chan_q;
  logic [3:0]  flags_q;
  logic [7:0]  lower_q;
  logic [7:0]  upper_q;

  // state machine sequencing
  wire ev_take   = ev_valid & ev_ready;
  wire slot_busy = mem_rdata[MRQ_NEW_BIT];
  always_comb begin
    next_state = state;
    unique case (state)
      MRQ_S_IDLE: if (ev_take) next_state = MRQ_S_RDNS;
      MRQ_S_RDNS: if (mem_ack) next_state = slot_busy ? MRQ_S_IDLE : MRQ_S_DATA;
      MRQ_S_DATA: if (mem_ack) next_state = stamp_q ? MRQ_S_TS : MRQ_S_STAT;
      MRQ_S_TS:   if (mem_ack) next_state = MRQ_S_ZERO;
      MRQ_S_ZERO: if (mem_ack) next_state = MRQ_S_STAT;
      MRQ_S_STAT: if (mem_ack) next_state = MRQ_S_IDLE;
      default:    next_state = MRQ_S_IDLE;
    endcase
  end

  // handshake and memory control
  assign ev_ready = ce & (state == MRQ_S_IDLE);
  assign mem_req  = (state != MRQ_S_IDLE);
  assign mem_we   = (state != MRQ_S_IDLE) & (state != MRQ_S_RDNS);
  wire ovf_event  = ce & (state == MRQ_S_RDNS) & mem_ack & slot_busy;
  wire entry_done = ce & (state == MRQ_S_STAT) & mem_ack;

  // entry contents
  wire [3:0]  flag_field  = vstar_q ? MRQ_VSTAR_FLAGS : flags_q;
  wire [7:0]  upper_field = vstar_q ? MRQ_VSTAR_UPPER : upper_q;
  wire [15:0] status_word = {1'b1, 3'h0, mux_q, chan_q, 4'h0, flag_field};
  wire [15:0] data_word   = {upper_field, lower_q};

  // word address of the next access
  wire [23:0] ptr_x2    = {7'h0, wr_ptr, 1'b0};
  wire [23:0] ptr_x4    = {6'h0, wr_ptr, 2'b00};
  // entry layout from the live setting while idle, latched once an event is taken
  wire        stamp_now = (state == MRQ_S_IDLE) ? time_stamp_enable : stamp_q;
  wire [23:0] entry_adr = queue_base + (stamp_now ? ptr_x4 : ptr_x2);
  wire [1:0]  next_off  = (next_state == MRQ_S_DATA) ? MRQ_WO_DATA :
                          (next_state == MRQ_S_TS)   ? MRQ_WO_TS   :
                          (next_state == MRQ_S_ZERO) ? MRQ_WO_ZERO : MRQ_WO_STAT;
  wire [15:0] next_wdata = (next_state == MRQ_S_DATA) ? data_word        :
                           (next_state == MRQ_S_TS)   ? time_stamp_value :
                           (next_state == MRQ_S_STAT) ? status_word      : 16'h0000;
  wire [15:0] ptr_inc    = wr_ptr + 16'h0001;
  wire [15:0] next_ptr   = (ptr_inc >= queue_size) ? 16'h0000 : ptr_inc;

  // state, pointer and memory outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= MRQ_S_IDLE;
      wr_ptr    <= 16'h0000;
      mem_addr  <= 24'h000000;
      mem_wdata <= 16'h0000;
    end else if (ce) begin
      state     <= next_state;
      mem_addr  <= entry_adr + {22'h0, next_off};
      mem_wdata <= next_wdata;
      if (entry_done) wr_ptr <= next_ptr;
    end
  end

  // event capture with its time stamp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_counter     <= 16'h0000;
      time_stamp_value <= 16'h0000;
      stamp_q          <= MRQ_STAMP_RST;
      vstar_q          <= 1'b0;
      mux_q            <= 1'b0;
      chan_q           <= 3'h0;
      flags_q          <= 4'h0;
      lower_q          <= 8'h00;
      upper_q          <= 8'h00;
    end else if (ce) begin
      free_counter <= free_counter + 16'h0001;
      if (ev_take) begin
        time_stamp_value <= free_counter;
        stamp_q          <= time_stamp_enable;
        vstar_q          <= ev_vstar;
        mux_q            <= ev_multiplex_select;
        chan_q           <= ev_channel_number;
        flags_q          <= {ev_odd, ev_abort, ev_first, ev_last};
        lower_q          <= ev_lower_monitor_byte;
        upper_q          <= ev_upper_monitor_byte;
      end
    end
  end

  // axi write decode
  wire        wr_go   = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire        wr_cfg  = wr_go & (s_axi_awaddr == MRQ_OFF_CFG);
  wire        wr_base = wr_go & (s_axi_awaddr == MRQ_OFF_BASE);
  wire        wr_size = wr_go & (s_axi_awaddr == MRQ_OFF_SIZE);
  wire        wr_ist  = wr_go & (s_axi_awaddr == MRQ_OFF_IRQ_STAT);
  wire        wr_imsk = wr_go & (s_axi_awaddr == MRQ_OFF_IRQ_MASK);
  wire        wr_map  = wr_cfg | wr_base | wr_size | wr_ist | wr_imsk |
                        (s_axi_awaddr == MRQ_OFF_STATUS);
  wire        clr_ovf = wr_ist & s_axi_wstrb[0] & s_axi_wdata[0];
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_stamp_enable <= MRQ_STAMP_RST;
      queue_base        <= MRQ_BASE_RST;
      queue_size        <= MRQ_SIZE_RST;
      overflow_mask     <= 1'b0;
    end else if (ce) begin
      if (wr_cfg && s_axi_wstrb[0]) time_stamp_enable <= s_axi_wdata[0];
      if (wr_base) queue_base <= s_axi_wdata[23:0];
      if (wr_size) queue_size <= s_axi_wdata[15:0];
      if (wr_imsk && s_axi_wstrb[0]) overflow_mask <= s_axi_wdata[0];
    end
  end

  // sticky overflow flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_queue_overflow <= 1'b0;
    end else if (ce) begin
      monitor_queue_overflow <= ovf_event | (monitor_queue_overflow & ~clr_ovf);
    end
  end
  assign irq = monitor_queue_overflow & overflow_mask;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= MRQ_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? MRQ_RESP_OKAY : MRQ_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  wire        rd_go  = ce & s_axi_arvalid & ~s_axi_rvalid;
  wire        rd_map = (s_axi_araddr == MRQ_OFF_CFG) | (s_axi_araddr == MRQ_OFF_BASE) |
                       (s_axi_araddr == MRQ_OFF_SIZE) | (s_axi_araddr == MRQ_OFF_IRQ_STAT) |
                       (s_axi_araddr == MRQ_OFF_IRQ_MASK) | (s_axi_araddr == MRQ_OFF_STATUS);
  wire [31:0] rd_val =
    (s_axi_araddr == MRQ_OFF_CFG)      ? {31'h0, time_stamp_enable}      :
    (s_axi_araddr == MRQ_OFF_BASE)     ? {8'h00, queue_base}             :
    (s_axi_araddr == MRQ_OFF_SIZE)     ? {16'h0000, queue_size}          :
    (s_axi_araddr == MRQ_OFF_IRQ_STAT) ? {31'h0, monitor_queue_overflow} :
    (s_axi_araddr == MRQ_OFF_IRQ_MASK) ? {31'h0, overflow_mask}          :
    (s_axi_araddr == MRQ_OFF_STATUS)   ? {15'h0, mem_req, wr_ptr}        : 32'h0;
  assign s_axi_arready = rd_go;

  // read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= MRQ_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_map ? MRQ_RESP_OKAY : MRQ_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks on the posting sequence
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  status_order_a: assert property (
    (state == MRQ_S_STAT) && $changed(state) |->
      ($past(state) == MRQ_S_DATA) || ($past(state) == MRQ_S_ZERO))
    else $error("status written before data");
  new_flag_a: assert property (
    (state == MRQ_S_STAT) |-> mem_we && mem_wdata[MRQ_NEW_BIT])
    else $error("status word without new flag");
  read_first_a: assert property (
    (state == MRQ_S_RDNS) |-> mem_req && !mem_we && (mem_addr == entry_adr))
    else $error("slot status not read first");
  ovf_set_a: assert property (
    (state == MRQ_S_RDNS) && mem_ack && slot_busy |=> monitor_queue_overflow
      && (state == MRQ_S_IDLE))
    else $error("overflow not flagged");
  ovf_clear_a: assert property (
    clr_ovf && !ovf_event |=> !monitor_queue_overflow)
    else $error("overflow flag not cleared");
  mux_bit_a: assert property (
    (state == MRQ_S_STAT) |-> mem_wdata[MRQ_MUX_BIT] == mux_q)
    else $error("wrong multiplex select");
  chan_field_a: assert property (
    (state == MRQ_S_STAT) |-> mem_wdata[MRQ_CHAN_LSB +: 3] == chan_q)
    else $error("wrong channel number");
  flag_copy_a: assert property (
    (state == MRQ_S_STAT) && !vstar_q |-> mem_wdata[3:0] == flags_q)
    else $error("message flags not copied");
  vstar_flags_a: assert property (
    (state == MRQ_S_STAT) && vstar_q |-> mem_wdata[3:0] == 4'hb)
    else $error("v star flags wrong");
  data_word_a: assert property (
    (state == MRQ_S_DATA) && !vstar_q |-> mem_wdata == {upper_q, lower_q})
    else $error("data word wrong");
  data_addr_a: assert property (
    (state == MRQ_S_DATA) |-> mem_addr == entry_adr + 24'h000001)
    else $error("data word misplaced");
  vstar_upper_a: assert property (
    (state == MRQ_S_DATA) && vstar_q |-> mem_wdata[15:8] == 8'hff)
    else $error("v star upper byte not all ones");
  ts_word_a: assert property (
    (state == MRQ_S_TS) |-> (mem_wdata == time_stamp_value)
      && (mem_addr == entry_adr + 24'h000002))
    else $error("time stamp word wrong");
  zero_word_a: assert property (
    (state == MRQ_S_ZERO) |-> (mem_wdata == 16'h0000) && stamp_q)
    else $error("closing word not zero");
  zero_addr_a: assert property (
    (state == MRQ_S_ZERO) |-> mem_addr == entry_adr + 24'h000003)
    else $error("closing word misplaced");
  no_advance_a: assert property (
    ovf_event |=> $stable(wr_ptr))
    else $error("pointer passed flagged slot");
  ptr_wrap_a: assert property (
    entry_done && (ptr_inc >= queue_size) |=> wr_ptr == 16'h0000)
    else $error("pointer did not wrap");

  overflow_seen_c: cover property (ovf_event);
  stamped_entry_c: cover property ((state == MRQ_S_ZERO) ##[1:20] entry_done);
  vstar_entry_c:   cover property (entry_done && vstar_q);
  plain_entry_c:   cover property (entry_done && !stamp_q && !vstar_q);
  wrap_c:          cover property (entry_done && (ptr_inc >= queue_size));
endmodule
`default_nettype wire

// ### dv/mrq_mem_model.sv
// shared memory model answering the queue writer's word port
`timescale 1ns/1ns
`default_nettype none
module mrq_mem_model (
  // clock
  input  wire logic        aclk,
  // memory word port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata,
  // answer delay in cycles
  input  wire logic [3:0]  delay
);
  logic [15:0] mem [0:255];
  logic [3:0]  cnt;
  // empty memory, no answer pending
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
    cnt = 4'h0;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // one ack per access; read data scrambled except on a read answer
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt == delay) begin
        mem_ack <= 1'b1;
        cnt <= 4'h0;
        if (mem_we)
          mem[mem_addr[7:0]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[7:0]];
      end else
        cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### dv/mrq_writer_bench.sv
// self-checking bench for the monitor receive queue writer
`timescale 1ns/1ns
`default_nettype none
module mrq_writer_bench;
  import mrq_pkg::*;
  logic        aclk, aresetn, ce, mem_req, mem_we, mem_ack, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ev_lower_monitor_byte, ev_upper_monitor_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, dly;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        ev_valid, ev_ready, ev_vstar, ev_multiplex_select;
  logic        ev_odd, ev_abort, ev_first, ev_last;
  logic [2:0]  ev_channel_number;
  logic [23:0] mem_addr;
  logic [15:0] mem_wdata, mem_rdata, ts_cnt, ts_exp;
  int          err_total, n_tests;
  mrq_writer mrq_writer_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ev_valid, .ev_ready,
    .ev_vstar, .ev_multiplex_select, .ev_channel_number, .ev_odd, .ev_abort, .ev_first,
    .ev_last, .ev_lower_monitor_byte, .ev_upper_monitor_byte, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .irq);
  mrq_mem_model mrq_mem_model_i (.aclk, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata, .delay(dly));
  // clock and bench copy of the free running stamp counter
  always #25 aclk = ~aclk;
  always @(posedge aclk) ts_cnt <= aresetn ? ts_cnt + 16'(ce) : 16'h0;
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_mem(input string nm, input logic [15:0] e, g);
    chk_reg(nm, {16'h0, e}, {16'h0, g});
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      err_total++;
      $display("MISMATCH wait expected 0 seen %0d", n);
      results();
    end
  endtask
  // one write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do @(posedge aclk); while (s_axi_awready !== 1'b1 && ++n < 300);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && ++n < 300);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk_reg("write resp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1 && ++n < 300);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1 && ++n < 300);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk_reg("read data", e, s_axi_rdata);
    chk_reg("read resp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // offer one event and wait until the writer is idle again
  task automatic post(input logic vs, mx, input logic [2:0] ch, input logic [3:0] fl,
                      input logic [15:0] b);
    int n;
    n = 0;
    {ev_vstar, ev_multiplex_select, ev_channel_number} <= {vs, mx, ch};
    {ev_odd, ev_abort, ev_first, ev_last, ev_upper_monitor_byte, ev_lower_monitor_byte} <= {fl, b};
    ev_valid <= 1'b1;
    do @(posedge aclk); while (ev_ready !== 1'b1 && ++n < 300);
    ts_exp = ts_cnt;
    ev_valid <= 1'b0;
    do @(posedge aclk); while (ev_ready !== 1'b1 && ++n < 300);
    tmo(n);
  endtask
  task automatic chk_entry(input int p, input logic ts, input logic [15:0] st, dat);
    int e;
    e = ts ? p * 4 : p * 2;
    chk_mem("status word", st, mrq_mem_model_i.mem[e]);
    chk_mem("data word", dat, mrq_mem_model_i.mem[e + 1]);
    if (ts) begin
      chk_mem("time stamp", ts_exp, mrq_mem_model_i.mem[e + 2]);
      chk_mem("zero word", 16'h0000, mrq_mem_model_i.mem[e + 3]);
    end
  endtask
  task automatic t_regs();
    axi_rd(MRQ_OFF_CFG, 32'h0, MRQ_RESP_OKAY);
    axi_rd(MRQ_OFF_SIZE, 32'h10, MRQ_RESP_OKAY);
    axi_rd(8'h40, 32'h0, MRQ_RESP_SLVERR);
    axi_wr(8'h40, 32'h1, MRQ_RESP_SLVERR);
    axi_rd(MRQ_OFF_IRQ_STAT, 32'h0, MRQ_RESP_OKAY);
    axi_rd(MRQ_OFF_IRQ_MASK, 32'h0, MRQ_RESP_OKAY);
    axi_rd(MRQ_OFF_BASE, 32'h0, MRQ_RESP_OKAY);
    axi_wr(MRQ_OFF_BASE, 32'hffabcd12, MRQ_RESP_OKAY);
    axi_rd(MRQ_OFF_BASE, 32'h00abcd12, MRQ_RESP_OKAY);
    axi_wr(MRQ_OFF_BASE, 32'h0, MRQ_RESP_OKAY);
    $display("test regs done");
  endtask
  // clock enable low: an offered event is not taken and nothing moves
  task automatic t_freeze();
    ce <= 1'b0;
    ev_valid <= 1'b1;
    repeat (4) @(posedge aclk);
    chk_mem("frozen ready", 16'h0, {15'h0, ev_ready});
    chk_mem("frozen busy", 16'h0, {15'h0, mem_req});
    {ce, ev_valid} <= 2'h2;
    @(posedge aclk);
    axi_rd(MRQ_OFF_STATUS, 32'h0, MRQ_RESP_OKAY);
    $display("test freeze done");
  endtask
  task automatic t_gci();
    logic [3:0] fl [4] = '{4'h2, 4'h1, 4'h9, 4'h4};
    for (int i = 0; i < 4; i++) begin
      post(1'b0, i[0], 3'(i + 3), fl[i], 16'h1234 + 16'(i));
      chk_entry(i, 1'b0, {4'h8, i[0], 3'(i + 3), 4'h0, fl[i]}, 16'h1234 + 16'(i));
    end
    axi_rd(MRQ_OFF_STATUS, 32'h4, MRQ_RESP_OKAY);
    $display("test gci done");
  endtask
  task automatic t_vstar();
    dly <= 4'h3;
    post(1'b1, 1'b1, 3'h7, 4'h4, 16'h005a);
    chk_entry(4, 1'b0, 16'h8f0b, 16'hff5a);
    dly <= 4'h0;
    $display("test vstar done");
  endtask
  task automatic t_tsv();
    axi_wr(MRQ_OFF_CFG, 32'h1, MRQ_RESP_OKAY);
    post(1'b0, 1'b0, 3'h2, 4'ha, 16'h00c3);
    chk_entry(5, 1'b1, 16'h820a, 16'h00c3);
    axi_wr(MRQ_OFF_CFG, 32'h0, MRQ_RESP_OKAY);
    $display("test stamp done");
  endtask
  task automatic t_wrap();
    axi_wr(MRQ_OFF_SIZE, 32'h8, MRQ_RESP_OKAY);
    post(1'b0, 1'b0, 3'h1, 4'h0, 16'h1111);
    post(1'b0, 1'b0, 3'h1, 4'h0, 16'h2222);
    chk_entry(7, 1'b0, 16'h8100, 16'h2222);
    axi_rd(MRQ_OFF_STATUS, 32'h0, MRQ_RESP_OKAY);
    post(1'b0, 1'b1, 3'h5, 4'h0, 16'h9999);
    chk_mem("kept data", 16'h1234, mrq_mem_model_i.mem[1]);
    chk_mem("irq masked", 16'h0, {15'h0, irq});
    axi_rd(MRQ_OFF_IRQ_STAT, 32'h1, MRQ_RESP_OKAY);
    axi_wr(MRQ_OFF_IRQ_MASK, 32'h1, MRQ_RESP_OKAY);
    chk_mem("irq raised", 16'h1, {15'h0, irq});
    axi_wr(MRQ_OFF_IRQ_STAT, 32'h1, MRQ_RESP_OKAY);
    chk_mem("irq cleared", 16'h0, {15'h0, irq});
    axi_rd(MRQ_OFF_STATUS, 32'h0, MRQ_RESP_OKAY);
    mrq_mem_model_i.mem[0] <= 16'h0000;
    post(1'b0, 1'b1, 3'h5, 4'h3, 16'h9999);
    chk_entry(0, 1'b0, 16'h8d03, 16'h9999);
    axi_rd(MRQ_OFF_STATUS, 32'h1, MRQ_RESP_OKAY);
    axi_wr(MRQ_OFF_BASE, 32'hff000080, MRQ_RESP_OKAY);
    axi_rd(MRQ_OFF_BASE, 32'h00000080, MRQ_RESP_OKAY);
    post(1'b0, 1'b0, 3'h6, 4'h1, 16'h4321);
    chk_mem("based status", 16'h8601, mrq_mem_model_i.mem[8'h82]);
    chk_mem("based data", 16'h4321, mrq_mem_model_i.mem[8'h83]);
    $display("test wrap done");
  endtask
  // reset, scenarios, verdict
  initial begin
    {aclk, aresetn, ce, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, dly} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {ev_valid, ev_vstar, ev_multiplex_select, ev_channel_number} = '0;
    {ev_odd, ev_abort, ev_first, ev_last, ev_lower_monitor_byte, ev_upper_monitor_byte} = '0;
    {err_total, n_tests, ts_cnt, ts_exp} = '0;
    ce = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_freeze();
    t_gci();
    t_vstar();
    t_tsv();
    t_wrap();
    results();
  end
endmodule
`default_nettype wire
